// [src/sss_defines.svh]
// timing counts, field positions and reset values of the sensor serial port
`ifndef SSS_DEFINES_SVH
`define SSS_DEFINES_SVH

`define SSS_CLK_MHZ 100
`define SSS_FRAME_BITS 16
`define SSS_WRITE_BIT 15
`define SSS_ADDR_HI 14
`define SSS_ADDR_LO 8
`define SSS_MODE_LIMIT 8'h09
`define SSS_PERIOD_ADDR 7'h36
`define SSS_SYNC_CTRL_ADDR 7'h32
`define SSS_SYNC_EN_BIT 2
`define SSS_PERIOD_RST 8'h01
`define SSS_DRDY_DELAY_US 600
`define SSS_DRDY_DELAY_CYC (`SSS_DRDY_DELAY_US * `SSS_CLK_MHZ)
`define SSS_DRDY_PULSE_US 1
`define SSS_DRDY_PULSE_CYC (`SSS_DRDY_PULSE_US * `SSS_CLK_MHZ)

`endif

// [src/sss_pkg.sv]
// types of the sensor serial port
package sss_pkg;
  typedef enum logic [1:0] {
    SSS_SYNC_IDLE = 2'b00,
    SSS_SYNC_WAIT = 2'b01,
    SSS_SYNC_PULSE = 2'b10
  } sss_sync_e;
  typedef logic [7:0] sss_byte_t;
endpackage : sss_pkg

// [src/sss_slave.sv]
// serial slave port with byte store, mode select and external sync pacing
// Notes on behaviour
// - output bits change on serial clock falling edges.
// - input bits are sampled on serial clock rising edges.
// - data ready pulses 600 us after a sync pulse when sync enabled; sync pulses during the wait or the ready pulse are ignored.
// - fourth io pin is a general output driving low or sync clock input by configuration.
// - normal mode when sample period setting <= 0x09, else low power.
// - read frame carries address; next frame returns addressed 16-bit word.
// - frame with top bit set writes low byte to its address at frame end.
// - mode 3 framing, msb first, 16-bit words.
`timescale 1ns/1ps
`include "sss_defines.svh"
module sss_slave #(
  parameter int DRDY_DELAY_CYC = `SSS_DRDY_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  input wire logic sync_clock_io_pin_i,
  output logic sync_clock_io_pin_o,
  output logic sync_clock_io_pin_oe,
  output logic data_ready,
  output logic low_power_mode
);
  default clocking cb_sys @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic cs_b_s;
  logic sclk_s;
  logic din_s;
  logic sync_s;
  // order: sync pin, din, sclk, cs_b; select and clock idle high
  localparam logic [3:0] PIN_RST = 4'h3;
  logic [3:0] pin_raw;
  logic [3:0] pin_s;
  assign pin_raw = {sync_clock_io_pin_i, din, sclk, cs_b};
  for (genvar gi = 0; gi < 4; gi++) begin : g_pin_sync
    sss_sync2 #(.RST_VAL(PIN_RST[gi])) u_sync2 (
      .clk(clk),
      .rst_b(rst_b),
      .d(pin_raw[gi]),
      .q(pin_s[gi])
    );
  end
  assign cs_b_s = pin_s[0];
  assign sclk_s = pin_s[1];
  assign din_s = pin_s[2];
  assign sync_s = pin_s[3];

  logic sclk_d_ff;
  logic sync_d_ff;
  logic rise;
  logic fall;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d_ff <= 1'b1;
      sync_d_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
      sync_d_ff <= sync_s;
    end
  end
  assign rise = !cs_b_s && sclk_s && !sclk_d_ff;
  assign fall = !cs_b_s && !sclk_s && sclk_d_ff;

  // ----------------------------------------------------------------
  // shift registers
  // ----------------------------------------------------------------
  logic [15:0] rx_ff;
  logic [4:0] cnt_ff;
  logic [15:0] tx_ff;
  logic frame_done;
  logic [15:0] nxt_rx;
  assign nxt_rx = {rx_ff[14:0], din_s};
  assign frame_done = rise && (cnt_ff == 5'(`SSS_FRAME_BITS - 1));

  // idle clock high: first edge is falling, so bit count runs on rises
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_ff <= 16'h0000;
      cnt_ff <= 5'h00;
    end else if (cs_b_s) begin
      cnt_ff <= 5'h00;
    end else if (rise) begin
      rx_ff <= nxt_rx;
      cnt_ff <= frame_done ? 5'h00 : cnt_ff + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // byte store and configuration
  // ----------------------------------------------------------------
  logic [7:0] mem_ff [0:127];
  logic [7:0] period_ff;
  logic sync_en_ff;
  logic [6:0] waddr;
  assign waddr = nxt_rx[`SSS_ADDR_HI:`SSS_ADDR_LO];

  always_ff @(posedge clk) begin
    if (frame_done && nxt_rx[`SSS_WRITE_BIT]) begin
      mem_ff[waddr] <= nxt_rx[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      period_ff <= `SSS_PERIOD_RST;
      sync_en_ff <= 1'b0;
    end else if (frame_done && nxt_rx[`SSS_WRITE_BIT]) begin
      if (waddr == `SSS_PERIOD_ADDR) begin
        period_ff <= nxt_rx[7:0];
      end
      if (waddr == `SSS_SYNC_CTRL_ADDR) begin
        sync_en_ff <= nxt_rx[`SSS_SYNC_EN_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_power_mode <= 1'b0;
    end else begin
      low_power_mode <= period_ff > `SSS_MODE_LIMIT;
    end
  end

  // ----------------------------------------------------------------
  // read return
  // ----------------------------------------------------------------
  // word = upper byte at odd address, lower at even; after a write frame
  // the next output is undefined, so the same lookup is simply reused
  logic [6:0] raddr;
  assign raddr = {nxt_rx[`SSS_ADDR_HI:`SSS_ADDR_LO+1], 1'b0};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_ff <= 16'h0000;
      dout <= 1'b0;
    end else begin
      if (frame_done) begin
        tx_ff <= {mem_ff[raddr | 7'h01], mem_ff[raddr]};
      end else if (fall) begin
        dout <= tx_ff[15];
        tx_ff <= {tx_ff[14:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // sync pacing and data ready
  // ----------------------------------------------------------------
  sss_pkg::sss_sync_e st_ff;
  logic [31:0] tmr_ff;
  logic sync_rise;
  assign sync_rise = sync_en_ff && sync_s && !sync_d_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= sss_pkg::SSS_SYNC_IDLE;
      tmr_ff <= 32'h0000_0000;
      data_ready <= 1'b0;
    end else begin
      case (st_ff)
        sss_pkg::SSS_SYNC_IDLE: begin
          data_ready <= 1'b0;
          if (sync_rise) begin
            st_ff <= sss_pkg::SSS_SYNC_WAIT;
            tmr_ff <= 32'(DRDY_DELAY_CYC - 1);
          end
        end
        sss_pkg::SSS_SYNC_WAIT: begin
          if (tmr_ff == 32'h0000_0000) begin
            st_ff <= sss_pkg::SSS_SYNC_PULSE;
            data_ready <= 1'b1;
            tmr_ff <= 32'(`SSS_DRDY_PULSE_CYC - 1);
          end else begin
            tmr_ff <= tmr_ff - 32'h0000_0001;
          end
        end
        sss_pkg::SSS_SYNC_PULSE: begin
          if (tmr_ff == 32'h0000_0000) begin
            st_ff <= sss_pkg::SSS_SYNC_IDLE;
            data_ready <= 1'b0;
          end else begin
            tmr_ff <= tmr_ff - 32'h0000_0001;
          end
        end
        default: begin
          st_ff <= sss_pkg::SSS_SYNC_IDLE;
          data_ready <= 1'b0;
        end
      endcase
    end
  end

  // pin as general output drives low when sync is off; input when on
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_clock_io_pin_o <= 1'b0;
      sync_clock_io_pin_oe <= 1'b0;
    end else begin
      sync_clock_io_pin_o <= 1'b0;
      sync_clock_io_pin_oe <= !sync_en_ff;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_write_frame;
    frame_done && nxt_rx[`SSS_WRITE_BIT];
  endsequence
  // write frames reload from a byte they overwrite, so only reads count
  sequence s_read_frame;
    frame_done && !nxt_rx[`SSS_WRITE_BIT];
  endsequence
  chk_mode_select: assert property (##1 low_power_mode ==
    ($past(period_ff) > `SSS_MODE_LIMIT))
    else $error("low power mode mismatch");
  chk_dout_on_fall: assert property (!$stable(dout) |-> $past(fall))
    else $error("dout changed without falling edge");
  chk_rx_on_rise: assert property (!$stable(rx_ff) |-> $past(rise))
    else $error("receive shift without rising edge");
  chk_write_store: assert property (s_write_frame |=>
    mem_ff[$past(waddr)] == $past(nxt_rx[7:0]))
    else $error("byte not stored");
  chk_read_load: assert property (s_read_frame |=>
    tx_ff[7:0] == mem_ff[$past(raddr)])
    else $error("read word not loaded");
  chk_pin_role: assert property (sync_en_ff |=> !sync_clock_io_pin_oe)
    else $error("pin driven while sync input");
  chk_drdy_late: assert property ((st_ff == sss_pkg::SSS_SYNC_IDLE) &&
    sync_rise |=> !data_ready [*8])
    else $error("data ready too early");
  chk_drdy_start: assert property ($rose(data_ready) |->
    $past(st_ff) == sss_pkg::SSS_SYNC_WAIT)
    else $error("data ready not from wait");
endmodule : sss_slave

// [src/sss_sync2.sv]
// two flip-flop synchroniser for one pin
`timescale 1ns/1ps
`include "sss_defines.svh"
module sss_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic d,
  output logic q
);
  logic meta_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule : sss_sync2

// [verification/sss_master_model.sv]
// master processor model driving the sensor serial port
`timescale 1ns/1ps
module sss_master_model (
  input wire logic clk,
  input wire logic slow,
  output logic cs_b,
  output logic sclk,
  output logic din,
  input wire logic dout
);
  initial begin
    cs_b = 1'b1;
    sclk = 1'b1;
    din = 1'b1;
  end
  // one frame; sclk stands high outside it, half period 8 clk
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(posedge clk);
    cs_b <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b0;
      din <= w[i];
      repeat (8) @(posedge clk);
      sclk <= 1'b1;
      r[i] = dout;
      repeat (8) @(posedge clk);
    end
    cs_b <= 1'b1;
    // released line shows the inverse so a stale bit is never trusted
    din <= ~w[0];
    repeat (slow ? 10000 : 4000) @(posedge clk);
  endtask : xfer
endmodule : sss_master_model

// [verification/test_sensor_spi_slave_timing_sync.sv]
// self-checking bench of the sensor serial slave port
`timescale 1ns/1ps
module test_sensor_spi_slave_timing_sync;
  localparam int DLY = 50;
  logic clk, rst_b, sync_drv, slow;
  logic cs_b, sclk, din, dout, pin_o, pin_oe, data_ready, low_power_mode;
  logic pin_level;
  logic [15:0] rd;
  int n_errors = 0;
  int checks_done = 0;
  assign pin_level = pin_oe ? pin_o : sync_drv;
  sss_slave #(.DRDY_DELAY_CYC(DLY)) DUT (
    .clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .din(din),
    .dout(dout), .sync_clock_io_pin_i(pin_level),
    .sync_clock_io_pin_o(pin_o), .sync_clock_io_pin_oe(pin_oe),
    .data_ready(data_ready), .low_power_mode(low_power_mode)
  );
  sss_master_model m (
    .clk(clk), .slow(slow), .cs_b(cs_b), .sclk(sclk), .din(din),
    .dout(dout)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic cmp(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic results();
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    cmp("drdy_rst", 16'h0000, {15'h0000, data_ready});
    cmp("lp_rst", 16'h0000, {15'h0000, low_power_mode});
    cmp("oe_rst", 16'h0001, {15'h0000, pin_oe});
    cmp("pin_o_rst", 16'h0000, {15'h0000, pin_o});
  endtask : t_reset
  task automatic t_write_read();
    m.xfer(16'hA05A, rd);
    m.xfer(16'hA1C3, rd);
    m.xfer(16'h2000, rd);
    m.xfer(16'h21FF, rd);
    cmp("word20", 16'hC35A, rd);
    m.xfer(16'h2000, rd);
    cmp("word20_odd", 16'hC35A, rd);
  endtask : t_write_read
  task automatic t_mode();
    m.xfer(16'hB609, rd);
    cmp("lp_09", 16'h0000, {15'h0000, low_power_mode});
    slow <= 1'b1;
    m.xfer(16'hB60A, rd);
    cmp("lp_0a", 16'h0001, {15'h0000, low_power_mode});
    m.xfer(16'h3600, rd);
    m.xfer(16'hB601, rd);
    cmp("period", 16'h000A, {8'h00, rd[7:0]});
    slow <= 1'b0;
    cmp("lp_01", 16'h0000, {15'h0000, low_power_mode});
  endtask : t_mode
  task automatic t_sync();
    int n;
    m.xfer(16'hB204, rd);
    cmp("oe_sync", 16'h0000, {15'h0000, pin_oe});
    n = 0;
    sync_drv <= 1'b1;
    // look between edges so the flag is settled when read
    @(negedge clk);
    while (data_ready !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    // two synchroniser stages and edge detect add a little slack
    cmp("drdy_delay", 16'h0001, {15'h0000, n >= DLY && n <= DLY + 6});
    repeat (50) @(negedge clk);
    cmp("drdy_hold", 16'h0001, {15'h0000, data_ready});
    repeat (500) @(posedge clk);
    cmp("drdy_end", 16'h0000, {15'h0000, data_ready});
    sync_drv <= 1'b0;
    repeat (10000) @(posedge clk);
    m.xfer(16'hB200, rd);
    cmp("oe_io", 16'h0001, {15'h0000, pin_oe});
  endtask : t_sync
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    results();
  end
  initial begin
    rst_b = 1'b0;
    sync_drv = 1'b0;
    slow = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    t_reset();
    t_write_read();
    t_mode();
    t_sync();
    results();
  end
endmodule : test_sensor_spi_slave_timing_sync
